// File: rtm_params.svh
`ifndef RTM_PARAMS_SVH
`define RTM_PARAMS_SVH

// byte offsets on the register bus
`define RTM_OFS_DOWHR 6'h00
`define RTM_OFS_MNSC 6'h04
`define RTM_OFS_MTHDY 6'h08
`define RTM_OFS_YEAR 6'h0C
`define RTM_OFS_CTRL 6'h10
`define RTM_OFS_ALCFG 6'h14
`define RTM_OFS_ALWKHR 6'h18
`define RTM_OFS_ALMNSC 6'h1C
`define RTM_OFS_ALMTDY 6'h20
`define RTM_OFS_STAT 6'h24
`define RTM_OFS_MASK 6'h28

// field positions
`define RTM_DOW_LSB 8
`define RTM_HOUR_LSB 0
`define RTM_MIN_LSB 8
`define RTM_SEC_LSB 0
`define RTM_MON_LSB 8
`define RTM_DAY_LSB 0
`define RTM_CTRL_UNLOCK 0
`define RTM_CTRL_RUN 1
`define RTM_CTRL_ALEN 2
`define RTM_EV_ALARM 0
`define RTM_EV_SECOND 1
`define RTM_EV_REJECT 2

// reset values
`define RTM_RST_SEC 7'h00
`define RTM_RST_MIN 7'h00
`define RTM_RST_HOUR 6'h00
`define RTM_RST_DOW 3'h0
`define RTM_RST_DAY 6'h01
`define RTM_RST_MON 5'h01
`define RTM_RST_YEAR 8'h00
`define RTM_RST_CTRL 3'h0
`define RTM_RST_CODE 4'h0

// digit limits
`define RTM_LAST_SEC 8'h59
`define RTM_LAST_MIN 8'h59
`define RTM_LAST_HOUR 8'h23
`define RTM_LAST_DOW 3'h6
`define RTM_LAST_MON 8'h12
`define RTM_LAST_YEAR 8'h99

`endif

// File: rtm_pkg.sv
package rtm_pkg;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } rtm_bus_state_t;

    typedef enum logic [3:0] {
        AL_HALF_SEC = 4'h0,
        AL_SECOND = 4'h1,
        AL_TEN_SEC = 4'h2,
        AL_MINUTE = 4'h3,
        AL_TEN_MIN = 4'h4,
        AL_HOUR = 4'h5,
        AL_DAY = 4'h6,
        AL_WEEK = 4'h7,
        AL_MONTH = 4'h8,
        AL_YEAR = 4'h9
    } rtm_alarm_code_t;
endpackage

// File: rtm_alarm_match.sv
`timescale 1ns/100ps
module rtm_alarm_match
    import rtm_pkg::*;
(
    input wire logic [3:0] alarmRepeatCode,
    input wire logic [6:0] curSec,
    input wire logic [6:0] curMin,
    input wire logic [5:0] curHour,
    input wire logic [2:0] curDow,
    input wire logic [5:0] curDay,
    input wire logic [4:0] curMon,
    input wire logic [6:0] alSec,
    input wire logic [6:0] alMin,
    input wire logic [5:0] alHour,
    input wire logic [2:0] alDow,
    input wire logic [5:0] alDay,
    input wire logic [4:0] alMon,
    output logic hit
);
    logic sOne, sTen, mOne, mTen, hr, wd, dy, mo;

    assign sOne = curSec[3:0] == alSec[3:0];
    assign sTen = curSec[6:4] == alSec[6:4];
    assign mOne = curMin[3:0] == alMin[3:0];
    assign mTen = curMin[6:4] == alMin[6:4];
    assign hr = curHour == alHour;
    assign wd = curDow == alDow;
    assign dy = curDay == alDay;
    assign mo = curMon == alMon;

    // only the digits the repeat code names are compared
    always_comb
    begin
        unique case (alarmRepeatCode)
            AL_HALF_SEC, AL_SECOND: hit = 1'b1; // see R10
            AL_TEN_SEC: hit = sOne; // see R10
            AL_MINUTE: hit = sOne & sTen; // see R10
            AL_TEN_MIN: hit = sOne & sTen & mOne; // see R10
            AL_HOUR: hit = sOne & sTen & mOne & mTen; // see R10
            AL_DAY: hit = sOne & sTen & mOne & mTen & hr; // see R10
            AL_WEEK: hit = sOne & sTen & mOne & mTen & hr & wd; // see R10
            AL_MONTH: hit = sOne & sTen & mOne & mTen & hr & dy; // see R10
            AL_YEAR: hit = sOne & sTen & mOne & mTen & hr & dy & mo; // see R11
            default: hit = 1'b0;
        endcase
    end
endmodule

// File: rtm_time_core.sv
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "rtm_params.svh"

// Functional notes
// R1: weekday digit bits 10:8, values 0-6
// R2: hour tens digit bits 5:4, 0-2
// R3: hour ones digit bits 3:0, 0-9
// R4: weekday/hours written only when unlocked
// R5: minute tens digit bits 14:12, 0-5
// R6: minute ones digit bits 11:8, 0-9
// R7: second tens digit bits 6:4, 0-5
// R8: second ones digit bits 3:0, 0-9
// R9: unused time register bits read zero
// R10: repeat code picks interval, compares matching digits
// R11: yearly code compares month and day too
// R12: digits roll over and carry upward
module rtm_time_core
    import rtm_pkg::*;
#(
    parameter int ADDR_W = 6
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic halfTick,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    output logic alarmPulse
);
    rtm_bus_state_t busState;
    logic [6:0] secR;
    logic [6:0] minR;
    logic [5:0] hourR;
    logic [2:0] dowR;
    logic [5:0] dayR;
    logic [4:0] monR;
    logic [7:0] yearR;
    logic [2:0] ctrl;
    logic [3:0] alarmRepeatCode;
    logic [6:0] alSec;
    logic [6:0] alMin;
    logic [5:0] alHour;
    logic [2:0] alDow;
    logic [5:0] alDay;
    logic [4:0] alMon;
    logic [2:0] status;
    logic [2:0] mask;
    logic halfPhase;
    logic secDone;
    logic hit;
    logic accept;
    logic wrAcc;
    logic rdStat;
    logic unlock;
    logic [15:0] wdata16;
    logic [31:0] rdMux;
    logic secStep;
    logic [2:0] events;
    logic [6:0] next_sec;
    logic [6:0] next_min;
    logic [5:0] next_hour;
    logic [2:0] next_dow;
    logic [5:0] next_day;
    logic [4:0] next_mon;
    logic [7:0] next_year;

    // two-digit bcd step: returns {wrapped, next}
    function automatic logic [8:0] bcd2Step(input logic [7:0] v,
        input logic [7:0] last, input logic [7:0] first);
        if (v == last)
            return {1'b1, first};
        else if (v[3:0] == 4'h9)
            return {1'b0, v[7:4] + 4'h1, 4'h0};
        else
            return {1'b0, v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic isLeap(input logic [7:0] y);
        if (y[4])
            return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        else
            return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
                (y[3:0] == 4'h8);
    endfunction

    function automatic logic [7:0] lastDay(input logic [4:0] m,
        input logic leap);
        unique case (m)
            5'h02: return leap ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: return 8'h30;
            default: return 8'h31;
        endcase
    endfunction

    // one wait cycle, answer on the second edge
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            busState <= BUS_IDLE;
        else
        begin
            unique case (busState)
                BUS_IDLE:
                    if (read || write)
                        busState <= BUS_DONE;
                BUS_DONE: busState <= BUS_IDLE;
            endcase
        end
    end

    assign waitrequest = (read || write) && (busState != BUS_DONE);
    assign accept = (read || write) && (busState == BUS_DONE);
    assign wrAcc = accept && write;
    assign rdStat = accept && read && (address == `RTM_OFS_STAT);
    assign unlock = ctrl[`RTM_CTRL_UNLOCK];
    assign wdata16 = writedata[15:0];

    always_comb
    begin
        rdMux = 32'h0000_0000;
        unique case (address)
            `RTM_OFS_DOWHR:
                rdMux[15:0] = {5'h00, dowR, 2'h0, hourR}; // see R1 R2 R3 R9
            `RTM_OFS_MNSC:
                rdMux[15:0] = {1'b0, minR, 1'b0, secR}; // see R5 R6 R7 R8 R9
            `RTM_OFS_MTHDY: rdMux[15:0] = {3'h0, monR, 2'h0, dayR};
            `RTM_OFS_YEAR: rdMux[7:0] = yearR;
            `RTM_OFS_CTRL: rdMux[2:0] = ctrl;
            `RTM_OFS_ALCFG: rdMux[3:0] = alarmRepeatCode;
            `RTM_OFS_ALWKHR: rdMux[15:0] = {5'h00, alDow, 2'h0, alHour};
            `RTM_OFS_ALMNSC: rdMux[15:0] = {1'b0, alMin, 1'b0, alSec};
            `RTM_OFS_ALMTDY: rdMux[15:0] = {3'h0, alMon, 2'h0, alDay};
            `RTM_OFS_STAT: rdMux[2:0] = status;
            `RTM_OFS_MASK: rdMux[2:0] = mask;
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // read data sampled in the wait cycle, stands at the answer edge
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            readdata <= 32'h0000_0000;
        else if (read && busState == BUS_IDLE)
            readdata <= rdMux;
    end

    // half-second phase: every second half tick advances the time
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            halfPhase <= 1'b0;
        else if (wrAcc && unlock && address == `RTM_OFS_MNSC)
            halfPhase <= 1'b0;
        else if (halfTick && ctrl[`RTM_CTRL_RUN])
            halfPhase <= ~halfPhase;
    end

    assign secStep = halfTick && ctrl[`RTM_CTRL_RUN] && halfPhase;

    // carry chain
    always_comb
    begin
        logic [8:0] s;
        logic [8:0] mi;
        logic [8:0] h;
        logic [8:0] d;
        logic [8:0] mo;
        logic [8:0] y;
        s = bcd2Step({1'b0, secR}, `RTM_LAST_SEC, 8'h00); // see R12
        mi = bcd2Step({1'b0, minR}, `RTM_LAST_MIN, 8'h00); // see R12
        h = bcd2Step({2'h0, hourR}, `RTM_LAST_HOUR, 8'h00); // see R12
        d = bcd2Step({2'h0, dayR}, lastDay(monR, isLeap(yearR)), 8'h01);
        mo = bcd2Step({3'h0, monR}, `RTM_LAST_MON, 8'h01);
        y = bcd2Step(yearR, `RTM_LAST_YEAR, 8'h00);
        next_sec = s[6:0];
        next_min = minR;
        next_hour = hourR;
        next_dow = dowR;
        next_day = dayR;
        next_mon = monR;
        next_year = yearR;
        if (s[8])
        begin
            next_min = mi[6:0];
            if (mi[8])
            begin
                next_hour = h[5:0];
                if (h[8])
                begin
                    next_dow = (dowR == `RTM_LAST_DOW) ? 3'h0 :
                        dowR + 3'h1; // see R12
                    next_day = d[5:0];
                    if (d[8])
                    begin
                        next_mon = mo[4:0];
                        if (mo[8])
                            next_year = y[7:0];
                    end
                end
            end
        end
    end

    // weekday and hours: write only while unlocked, write beats tick
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            dowR <= `RTM_RST_DOW;
            hourR <= `RTM_RST_HOUR;
        end
        else if (wrAcc && unlock && address == `RTM_OFS_DOWHR) // see R4
        begin
            if (byteenable[1])
                dowR <= wdata16[`RTM_DOW_LSB +: 3]; // see R1
            if (byteenable[0])
                hourR <= wdata16[`RTM_HOUR_LSB +: 6]; // see R2 R3
        end
        else if (secStep)
        begin
            dowR <= next_dow;
            hourR <= next_hour;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            minR <= `RTM_RST_MIN;
            secR <= `RTM_RST_SEC;
        end
        else if (wrAcc && unlock && address == `RTM_OFS_MNSC)
        begin
            if (byteenable[1])
                minR <= wdata16[`RTM_MIN_LSB +: 7]; // see R5 R6
            if (byteenable[0])
                secR <= wdata16[`RTM_SEC_LSB +: 7]; // see R7 R8
        end
        else if (secStep)
        begin
            minR <= next_min;
            secR <= next_sec;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            monR <= `RTM_RST_MON;
            dayR <= `RTM_RST_DAY;
            yearR <= `RTM_RST_YEAR;
        end
        else
        begin
            if (wrAcc && unlock && address == `RTM_OFS_MTHDY)
            begin
                if (byteenable[1])
                    monR <= wdata16[`RTM_MON_LSB +: 5];
                if (byteenable[0])
                    dayR <= wdata16[`RTM_DAY_LSB +: 6];
            end
            else if (secStep)
            begin
                monR <= next_mon;
                dayR <= next_day;
            end
            if (wrAcc && unlock && address == `RTM_OFS_YEAR &&
                byteenable[0])
                yearR <= wdata16[7:0];
            else if (secStep)
                yearR <= next_year;
        end
    end

    // control and alarm setup
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= `RTM_RST_CTRL;
            alarmRepeatCode <= `RTM_RST_CODE;
            mask <= 3'h0;
        end
        else if (wrAcc && byteenable[0])
        begin
            if (address == `RTM_OFS_CTRL)
                ctrl <= wdata16[2:0];
            if (address == `RTM_OFS_ALCFG)
                alarmRepeatCode <= wdata16[3:0]; // see R10
            if (address == `RTM_OFS_MASK)
                mask <= wdata16[2:0];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            alDow <= 3'h0;
            alHour <= 6'h00;
            alMin <= 7'h00;
            alSec <= 7'h00;
            alMon <= 5'h01;
            alDay <= 6'h01;
        end
        else if (wrAcc)
        begin
            if (address == `RTM_OFS_ALWKHR)
            begin
                if (byteenable[1])
                    alDow <= wdata16[`RTM_DOW_LSB +: 3];
                if (byteenable[0])
                    alHour <= wdata16[`RTM_HOUR_LSB +: 6];
            end
            if (address == `RTM_OFS_ALMNSC)
            begin
                if (byteenable[1])
                    alMin <= wdata16[`RTM_MIN_LSB +: 7];
                if (byteenable[0])
                    alSec <= wdata16[`RTM_SEC_LSB +: 7];
            end
            if (address == `RTM_OFS_ALMTDY)
            begin
                if (byteenable[1])
                    alMon <= wdata16[`RTM_MON_LSB +: 5];
                if (byteenable[0])
                    alDay <= wdata16[`RTM_DAY_LSB +: 6];
            end
        end
    end

    rtm_alarm_match u_match (
        .alarmRepeatCode(alarmRepeatCode),
        .curSec(secR),
        .curMin(minR),
        .curHour(hourR),
        .curDow(dowR),
        .curDay(dayR),
        .curMon(monR),
        .alSec(alSec),
        .alMin(alMin),
        .alHour(alHour),
        .alDow(alDow),
        .alDay(alDay),
        .alMon(alMon),
        .hit(hit)
    );

    // compare the advanced time one cycle after the step
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            secDone <= 1'b0;
            alarmPulse <= 1'b0;
        end
        else
        begin
            secDone <= secStep;
            if (!ctrl[`RTM_CTRL_ALEN])
                alarmPulse <= 1'b0;
            else if (alarmRepeatCode == AL_HALF_SEC)
                alarmPulse <= halfTick && ctrl[`RTM_CTRL_RUN]; // see R10
            else
                alarmPulse <= secDone && hit; // see R10 R11
        end
    end

    assign events[`RTM_EV_ALARM] = alarmPulse;
    assign events[`RTM_EV_SECOND] = secDone;
    assign events[`RTM_EV_REJECT] = wrAcc && !unlock &&
        (address == `RTM_OFS_DOWHR || address == `RTM_OFS_MNSC ||
        address == `RTM_OFS_MTHDY || address == `RTM_OFS_YEAR);

    // sticky status, cleared by the read that returned it; set wins
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            status <= 3'h0;
        else
            status <= (status & ~(rdStat ? readdata[2:0] : 3'h0)) | events;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(((status & ~(rdStat ? readdata[2:0] : 3'h0)) | events)
                & mask);
    end
endmodule

// File: rtm_core_monitor.sv
`timescale 1ns/100ps
`include "rtm_params.svh"
module rtm_core_monitor
#(
    parameter int ADDR_W = 6
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic halfTick,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic irq,
    input wire logic alarmPulse
);
    logic [3:0] sinceTick;
    logic rdWh;
    logic rdMs;

    assign rdWh = read && !waitrequest && address == `RTM_OFS_DOWHR;
    assign rdMs = read && !waitrequest && address == `RTM_OFS_MNSC;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // cycles since the last half-second tick, saturating
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            sinceTick <= 4'hF;
        else if (halfTick)
            sinceTick <= 4'h0;
        else if (sinceTick != 4'hF)
            sinceTick <= sinceTick + 4'h1;
    end

    property p_whZero;
        rdWh |-> readdata[15:11] == 5'h00 && readdata[7:6] == 2'h0;
    endproperty
    a_whZero: assert property (p_whZero)
        else $error("weekday-hours spare bits set");
    property p_msZero;
        rdMs |-> readdata[15] == 1'b0 && readdata[7] == 1'b0;
    endproperty
    a_msZero: assert property (p_msZero)
        else $error("minutes-seconds spare bits set");
    property p_day_of_week_digit;
        rdWh |-> readdata[10:8] <= 3'h6;
    endproperty
    a_day_of_week_digit: assert property (p_day_of_week_digit)
        else $error("weekday digit out of range");
    property p_hour_tens_digit;
        rdWh |-> readdata[5:4] <= 2'h2;
    endproperty
    a_hour_tens_digit: assert property (p_hour_tens_digit)
        else $error("hour tens out of range");
    property p_hour_units_digit;
        rdWh |-> readdata[3:0] <= 4'h9;
    endproperty
    a_hour_units_digit: assert property (p_hour_units_digit)
        else $error("hour units out of range");
    property p_mnTen;
        rdMs |-> readdata[14:12] <= 3'h5;
    endproperty
    a_mnTen: assert property (p_mnTen)
        else $error("minute tens out of range");
    property p_mnOne;
        rdMs |-> readdata[11:8] <= 4'h9;
    endproperty
    a_mnOne: assert property (p_mnOne)
        else $error("minute units out of range");
    property p_scTen;
        rdMs |-> readdata[6:4] <= 3'h5;
    endproperty
    a_scTen: assert property (p_scTen)
        else $error("second tens out of range");
    property p_scOne;
        rdMs |-> readdata[3:0] <= 4'h9;
    endproperty
    a_scOne: assert property (p_scOne)
        else $error("second units out of range");
    property p_pulse;
        alarmPulse |=> !alarmPulse;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("alarm pulse longer than one cycle");
    property p_cause;
        alarmPulse |-> sinceTick <= 4'h4;
    endproperty
    a_cause: assert property (p_cause)
        else $error("alarm pulse without a recent tick");
    property p_wait;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_wait: assert property (p_wait)
        else $error("request not answered after one wait");

    c_pulse: cover property (alarmPulse);
    c_irq: cover property ($rose(irq));
    c_wr: cover property (write && !waitrequest && rdWh == 1'b0);
endmodule

bind rtm_time_core rtm_core_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .mclk(mclk), .rst(rst), .halfTick(halfTick), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .alarmPulse(alarmPulse));

// File: tb.sv
`timescale 1ns/100ps
`include "rtm_params.svh"
module tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic halfTick = 1'b0;
    logic [5:0] address = 6'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic irq;
    logic alarmPulse;
    logic [31:0] rd = 32'h00000000;
    logic [31:0] pulses = 32'h00000000;
    int errors = 0;
    int tests_run = 0;

    rtm_time_core #(.ADDR_W(6)) DUT (
        .mclk(mclk), .rst(rst), .halfTick(halfTick), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .alarmPulse(alarmPulse));

    initial
    begin
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk)
        if (alarmPulse === 1'b1)
            pulses <= pulses + 32'h1;

    task automatic complete_run();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one Avalon transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [15:0] d);
        @(posedge mclk);
        address <= a;
        writedata <= {16'h0000, d};
        byteenable <= 4'h3;
        write <= wr;
        read <= !wr;
        @(posedge mclk);
        while (waitrequest !== 1'b0)
            @(posedge mclk);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic tick();
        @(posedge mclk);
        halfTick <= 1'b1;
        @(posedge mclk);
        halfTick <= 1'b0;
        repeat (10) @(posedge mclk);
    endtask

    task automatic t_reset();
        bus(1'b0, `RTM_OFS_DOWHR, 16'h0000);
        check(rd, 32'h00000000);
        bus(1'b0, `RTM_OFS_MNSC, 16'h0000);
        check(rd, 32'h00000000);
        bus(1'b0, 6'h2C, 16'h0000);
        check(rd, 32'h00000000);
    endtask

    task automatic t_lock();
        bus(1'b1, `RTM_OFS_DOWHR, 16'h0623);
        bus(1'b0, `RTM_OFS_DOWHR, 16'h0000);
        check(rd, 32'h00000000);
        bus(1'b0, `RTM_OFS_STAT, 16'h0000);
        check(rd, 32'h00000004);
        bus(1'b0, `RTM_OFS_STAT, 16'h0000);
        check(rd, 32'h00000000);
    endtask

    task automatic t_fields();
        bus(1'b1, `RTM_OFS_CTRL, 16'h0001);
        bus(1'b1, `RTM_OFS_DOWHR, 16'hF823);
        bus(1'b1, `RTM_OFS_MNSC, 16'hD9D9);
        bus(1'b0, `RTM_OFS_DOWHR, 16'h0000);
        check(rd, 32'h00000023);
        bus(1'b0, `RTM_OFS_MNSC, 16'h0000);
        check(rd, 32'h00005959);
        bus(1'b1, `RTM_OFS_DOWHR, 16'h0600);
        bus(1'b0, `RTM_OFS_DOWHR, 16'h0000);
        check(rd, 32'h00000600);
    endtask

    task automatic t_roll();
        bus(1'b1, `RTM_OFS_CTRL, 16'h0003);
        bus(1'b1, `RTM_OFS_MNSC, 16'h0909);
        tick();
        tick();
        bus(1'b0, `RTM_OFS_MNSC, 16'h0000);
        check(rd, 32'h00000910);
        bus(1'b1, `RTM_OFS_DOWHR, 16'h0623);
        bus(1'b1, `RTM_OFS_MNSC, 16'h5959);
        tick();
        tick();
        bus(1'b0, `RTM_OFS_DOWHR, 16'h0000);
        check(rd, 32'h00000000);
        bus(1'b0, `RTM_OFS_MNSC, 16'h0000);
        check(rd, 32'h00000000);
    endtask

    // four half-second ticks, i.e. two second steps, counting alarms
    task automatic t_alarm(input logic [3:0] code, input logic [15:0] date,
                           input logic [15:0] wh, input logic [15:0] ms,
                           input logic [31:0] exp);
        logic [31:0] base;
        bus(1'b1, `RTM_OFS_ALCFG, {12'h000, code});
        bus(1'b1, `RTM_OFS_MTHDY, date);
        bus(1'b1, `RTM_OFS_DOWHR, wh);
        bus(1'b1, `RTM_OFS_MNSC, ms);
        base = pulses;
        repeat (4) tick();
        check(pulses - base, exp);
    endtask

    task automatic t_irq();
        bus(1'b1, `RTM_OFS_ALCFG, 16'h0000);
        bus(1'b1, `RTM_OFS_MASK, 16'h0001);
        bus(1'b0, `RTM_OFS_STAT, 16'h0000);
        tick();
        check({31'h0, irq}, 32'h00000001);
        bus(1'b0, `RTM_OFS_STAT, 16'h0000);
        check(rd & 32'h00000001, 32'h00000001);
        repeat (3) @(posedge mclk);
        check({31'h0, irq}, 32'h00000000);
        bus(1'b1, `RTM_OFS_MASK, 16'h0000);
        tick();
        check({31'h0, irq}, 32'h00000000);
    endtask

    initial
    begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_lock();
        t_fields();
        t_roll();
        bus(1'b1, `RTM_OFS_CTRL, 16'h0007);
        t_alarm(4'h0, 16'h0101, 16'h0000, 16'h0000, 32'h4);
        t_alarm(4'h1, 16'h0101, 16'h0000, 16'h0000, 32'h2);
        t_alarm(4'h2, 16'h0101, 16'h0000, 16'h0008, 32'h1);
        t_alarm(4'h3, 16'h0101, 16'h0000, 16'h0058, 32'h1);
        t_alarm(4'h4, 16'h0101, 16'h0000, 16'h0958, 32'h1);
        t_alarm(4'h5, 16'h0101, 16'h0000, 16'h5958, 32'h1);
        t_alarm(4'h6, 16'h0101, 16'h0023, 16'h5958, 32'h1);
        t_alarm(4'h7, 16'h0101, 16'h0623, 16'h5958, 32'h1);
        t_alarm(4'h8, 16'h0131, 16'h0023, 16'h5958, 32'h1);
        t_alarm(4'h9, 16'h1231, 16'h0023, 16'h5958, 32'h1);
        t_alarm(4'h9, 16'h0131, 16'h0023, 16'h5958, 32'h0);
        t_alarm(4'hA, 16'h0101, 16'h0000, 16'h0000, 32'h0);
        t_irq();
        complete_run();
    end

    initial
    begin
        #2000000;
        errors++;
        complete_run();
    end
endmodule
